// file: rtl/vcxo_pkg.sv
// Summary of operation
// - Low-speed code n divides by 2^n, max 32
// - High-speed divider: 5-33 any, 34-2046 even
// - Odd low-range high-speed ratios get duty correction
// - All divider settings are unsigned only
// - Crystal 152.6 MHz, VCO 10.8 to 13.122222022 GHz
// - Grades limit output and VCO maximum frequency
// - Output equals VCO over both divide ratios
// - VCO equals crystal times feedback, pulled by gain
// - Centre feedback divider is VCO over crystal
// - VCO change requires gain recalibration
// - Gain is round(128*80e6/(VCO/prescaler/8))
// - Prescaler 16/18/20/22 by feedback integer
// - Feedback integer taken by truncation
// - Smallest low-speed ratio keeping high-speed legal
// - Nearest legal high-speed divider above VCO minimum
// - Reject plans outside grade VCO range
// - Feedback word is 11.32 unsigned fixed point
// - Fraction is truncated fraction times 2^32
// - Packed register: low-speed 6:4, high-speed 2:0
package vcxo_pkg;

    // Frequencies in Hz
    localparam logic [27:0] FOSC_HZ = 28'h9187dc0; // 152.6 MHz crystal
    localparam logic [35:0] FVCO_MIN_HZ = 36'h283baec00; // 10.8 GHz
    localparam logic [35:0] FVCO_MAX_A = 36'h30e2537c6; // 13.122222022 GHz
    localparam logic [35:0] FVCO_MAX_B = 36'h2e9c43b22; // 12.511886114 GHz
    localparam logic [35:0] FVCO_MAX_CD = 36'h2d793bcd0; // 12.206718160 GHz
    localparam logic [31:0] FOUT_MAX_A = 32'hb2d05e00; // 3000 MHz
    localparam logic [31:0] FOUT_MAX_B = 32'h59682f00; // 1500 MHz
    localparam logic [31:0] FOUT_MAX_C = 32'h2faf0800; // 800 MHz
    localparam logic [31:0] FOUT_MAX_D = 32'h135f1b40; // 325 MHz

    // Divider limits
    localparam int FB_INT_W = 11;
    localparam int FB_FRAC_W = 32;
    localparam int FB_W = FB_INT_W + FB_FRAC_W;
    localparam logic [10:0] HS_MIN = 11'h005;
    localparam logic [10:0] HS_ODD_MAX = 11'h021;
    localparam logic [10:0] HS_MAX = 11'h7fe;
    localparam logic [2:0] LS_CODE_MAX = 3'h5;

    // Gain calibration constants
    localparam logic [26:0] ADC_NOM_HZ = 27'h4c4b400; // 80 MHz
    localparam logic [7:0] GAIN_SCALE = 8'h80; // 128
    localparam logic [3:0] ADC_PRE_DIV = 4'h8; // 8
    localparam logic [10:0] PRESC_T1 = 11'h048; // 72
    localparam logic [10:0] PRESC_T2 = 11'h04f; // 79
    localparam logic [10:0] PRESC_T3 = 11'h056; // 86
    localparam logic [4:0] PRESC_V0 = 5'h10; // 16
    localparam logic [4:0] PRESC_V1 = 5'h12; // 18
    localparam logic [4:0] PRESC_V2 = 5'h14; // 20
    localparam logic [4:0] PRESC_V3 = 5'h16; // 22

    // Register addresses
    localparam logic [7:0] ADDR_HS_LO = 8'h17; // 23
    localparam logic [7:0] ADDR_PACKED = 8'h18; // 24
    localparam logic [7:0] ADDR_FB0 = 8'h1a; // 26, then 27..31
    localparam logic [7:0] ADDR_FB5 = 8'h1f; // 31
    localparam logic [7:0] ADDR_GAIN = 8'h23; // 35
    localparam int PK_LS_LSB = 4;
    localparam int PK_HS_LSB = 0;
    localparam logic [3:0] WRITE_COUNT = 4'h9;

    // Values after reset (156.75 MHz centre)
    localparam logic [10:0] HS_RESET = 11'h046;
    localparam logic [2:0] LS_RESET = 3'h0;
    localparam logic [42:0] FB_RESET = 43'h047e756e62a;
    localparam logic [7:0] GAIN_RESET = 8'h77;

    // Scale of the pull term: ppm times millivolts
    localparam logic [29:0] PULL_SCALE = 30'h3b9aca00; // 1e9

    typedef enum logic [2:0] {
        ST_IDLE, ST_RANGE, ST_PICK, ST_VCO, ST_FB, ST_GAIN, ST_WRITE
    } plan_state_t;

    // VCO ceiling of a speed grade
    function automatic logic [35:0] fvco_max(input logic [1:0] g);
        case (g)
            2'h0: fvco_max = FVCO_MAX_A;
            2'h1: fvco_max = FVCO_MAX_B;
            default: fvco_max = FVCO_MAX_CD;
        endcase
    endfunction

    // Output ceiling of a speed grade
    function automatic logic [31:0] fout_max(input logic [1:0] g);
        case (g)
            2'h0: fout_max = FOUT_MAX_A;
            2'h1: fout_max = FOUT_MAX_B;
            2'h2: fout_max = FOUT_MAX_C;
            default: fout_max = FOUT_MAX_D;
        endcase
    endfunction

endpackage

// file: rtl/vcxo_link_if.sv
`timescale 1ns/1ps
// Register path between planner and oscillator
interface vcxo_link_if (
    input wire logic ref_clk // Shared clock
);
    logic wr; // Write strobe, one cycle
    logic rd; // Read strobe, one cycle
    logic [7:0] addr; // Register address
    logic [7:0] wdata; // Write data
    logic [7:0] rdata; // Read data, cycle after rd

    modport device (input wr, input rd, input addr, input wdata,
        output rdata);
    modport host (output wr, output rd, output addr, output wdata,
        input rdata);
endinterface

// file: rtl/vcxo_device.sv
`timescale 1ns/1ps
// Oscillator end: divider registers and the frequency they yield
module vcxo_device
    import vcxo_pkg::*;
(
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset, high
    vcxo_link_if.device link, // Register path
    input wire logic signed [15:0] control_voltage_mv, // Vc minus VDD/2
    input wire logic [15:0] tuning_gain_ppm_per_volt, // Pull gain
    output logic [5:0] low_speed_ratio, // Low-speed divide ratio
    output logic [10:0] high_speed_ratio, // High-speed divide ratio
    output logic duty_fix_en, // Duty correction active
    output logic hs_setting_bad, // High-speed value illegal
    output logic [35:0] fvco_hz, // Pulled VCO frequency
    output logic [35:0] fout_hz // Output frequency
);
    logic [10:0] high_speed_divider_q; // Unsigned divider words
    logic [2:0] low_speed_divider_q;
    logic [42:0] feedback_divider_q;
    logic [7:0] vc_adc_fullscale_gain_q;
    logic [7:0] rdata_q;
    logic [5:0] ls_ratio_q;
    logic [10:0] hs_ratio_q;
    logic dcc_q;
    logic bad_q;
    logic [35:0] base_q; // Centre VCO frequency
    logic [35:0] fvco_q;
    logic [35:0] fout_q;
    logic [47:0] fb_ext; // Feedback word padded to bytes
    logic [2:0] fb_byte; // Byte index in feedback word
    logic [78:0] base_prod; // Crystal times feedback
    logic signed [71:0] pull; // Signed pull in Hz
    logic signed [71:0] pulled; // Pulled VCO, before clamp
    logic [35:0] after_ls; // VCO after the low-speed stage

    assign fb_ext = {5'h00, feedback_divider_q};
    assign fb_byte = 3'(link.addr - ADDR_FB0);

    // Register writes; fields stay unsigned
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            high_speed_divider_q <= HS_RESET;
            low_speed_divider_q <= LS_RESET;
            feedback_divider_q <= FB_RESET;
            vc_adc_fullscale_gain_q <= GAIN_RESET;
        end else if (link.wr) begin
            if (link.addr == ADDR_HS_LO) begin
                high_speed_divider_q[7:0] <= link.wdata;
            end else if (link.addr == ADDR_PACKED) begin
                // Packed layout, bits 7 and 3 dropped
                low_speed_divider_q <= link.wdata[PK_LS_LSB +: 3];
                high_speed_divider_q[10:8] <= link.wdata[PK_HS_LSB +: 3];
            end else if (link.addr >= ADDR_FB0 && link.addr <= ADDR_FB5) begin
                // 11.32 word written a byte at a time
                case (fb_byte)
                    3'h0: feedback_divider_q[7:0] <= link.wdata;
                    3'h1: feedback_divider_q[15:8] <= link.wdata;
                    3'h2: feedback_divider_q[23:16] <= link.wdata;
                    3'h3: feedback_divider_q[31:24] <= link.wdata;
                    3'h4: feedback_divider_q[39:32] <= link.wdata;
                    default: feedback_divider_q[42:40] <= link.wdata[2:0];
                endcase
            end else if (link.addr == ADDR_GAIN) begin
                vc_adc_fullscale_gain_q <= link.wdata;
            end
        end
    end

    // Read data stand in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (!link.rd) begin
            rdata_q <= 8'h00;
        end else if (link.addr == ADDR_HS_LO) begin
            rdata_q <= high_speed_divider_q[7:0];
        end else if (link.addr == ADDR_PACKED) begin
            rdata_q <= {1'b0, low_speed_divider_q, 1'b0,
                high_speed_divider_q[10:8]};
        end else if (link.addr >= ADDR_FB0 && link.addr <= ADDR_FB5) begin
            rdata_q <= fb_ext[{fb_byte, 3'h0} +: 8];
        end else if (link.addr == ADDR_GAIN) begin
            rdata_q <= vc_adc_fullscale_gain_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign link.rdata = rdata_q;

    // Divider decode and legality
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ls_ratio_q <= 6'h01;
            hs_ratio_q <= HS_RESET;
            dcc_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            // Codes above five saturate at 32
            ls_ratio_q <= (low_speed_divider_q > LS_CODE_MAX) ? 6'h20
                : 6'(6'h01 << low_speed_divider_q);
            hs_ratio_q <= high_speed_divider_q;
            // Odd low-range ratios keep 50% duty
            dcc_q <= high_speed_divider_q[0]
                && high_speed_divider_q <= HS_ODD_MAX;
            // Out of range, or odd above 33
            bad_q <= high_speed_divider_q < HS_MIN
                || high_speed_divider_q > HS_MAX
                || (high_speed_divider_q > HS_ODD_MAX
                    && high_speed_divider_q[0]);
        end
    end

    // Centre VCO from crystal and feedback word
    assign base_prod = {51'h0, FOSC_HZ} * {36'h0, feedback_divider_q};
    // Pull term: base * mV * ppm / 1e9, signed about half supply
    assign pull = (signed'({36'h0, base_q})
        * 72'(control_voltage_mv)
        * signed'({56'h0, tuning_gain_ppm_per_volt}))
        / signed'({42'h0, PULL_SCALE});
    assign pulled = signed'({36'h0, base_q}) + pull;
    // Low-speed stage is a shift, code above five saturates
    assign after_ls = fvco_q >> ((low_speed_divider_q > LS_CODE_MAX)
        ? LS_CODE_MAX : low_speed_divider_q);

    // Frequency pipeline, three stages
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            base_q <= 36'h0;
            fvco_q <= 36'h0;
            fout_q <= 36'h0;
        end else begin
            base_q <= base_prod[67:32];
            fvco_q <= pulled[71] ? 36'h0 : pulled[35:0];
            // Output is VCO over both ratios
            fout_q <= (high_speed_divider_q == 11'h0) ? 36'h0
                : after_ls / {25'h0, high_speed_divider_q};
        end
    end

    assign low_speed_ratio = ls_ratio_q;
    assign high_speed_ratio = hs_ratio_q;
    assign duty_fix_en = dcc_q;
    assign hs_setting_bad = bad_q;
    assign fvco_hz = fvco_q;
    assign fout_hz = fout_q;
endmodule

// file: rtl/vcxo_planner.sv
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Host end: derives dividers and gain, then writes them to the oscillator
module vcxo_planner
    import vcxo_pkg::*;
#(
    parameter int FOUT_W = 32 // Width of the requested frequency
)(
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset, high
    input wire logic start, // Plan request pulse
    input wire logic [FOUT_W-1:0] fout_req_hz, // Wanted output, Hz
    input wire logic [1:0] speed_grade, // 0..3 for the four grades
    vcxo_link_if.host link, // Register path
    output logic busy, // Plan or write in progress
    output logic done, // Pulse: plan written
    output logic plan_error, // Pulse: no valid plan
    output logic [2:0] low_speed_divider, // Low-speed code
    output logic [10:0] high_speed_divider, // High-speed value
    output logic [42:0] feedback_divider, // 11.32 feedback word
    output logic [4:0] gain_prescaler_value, // Prescaler used
    output logic [7:0] vc_adc_fullscale_gain // Gain calibration
);
    // Products below are sized for at most 32 bits of frequency
    if (FOUT_W < 1 || FOUT_W > 32) begin : g_bad_width
        $error("FOUT_W must lie in 1..32");
    end

    plan_state_t state_q;
    logic [31:0] fout_q; // Captured request
    logic [1:0] grade_q;
    logic [2:0] ls_q;
    logic [10:0] hs_q;
    logic [35:0] fvco_q;
    logic [42:0] fb_q;
    logic [4:0] presc_q;
    logic [7:0] gain_q;
    logic [3:0] widx_q; // Register write index
    logic wr_q;
    logic [7:0] addr_q;
    logic [7:0] wdata_q;
    logic busy_q;
    logic done_q;
    logic err_q;
    logic [47:0] step; // fout times low-speed ratio
    logic [47:0] min_div; // Ceiling of VCO min over step
    logic [47:0] hs_try; // High-speed candidate, before parity fix
    logic [47:0] hs_fix; // Legal candidate
    logic [58:0] fvco_full; // step times high-speed value
    logic [71:0] fb_full; // VCO scaled by 2^32 over crystal
    logic [42:0] gain_num; // 128 * 80e6 * 8 * prescaler
    logic [42:0] gain_full; // Rounded quotient
    logic [4:0] presc_sel; // Prescaler for the feedback integer
    logic [10:0] fb_int; // Truncated integer part
    logic [47:0] wr_word; // Next write, address and data

    // Ceiling of the minimum total divider
    assign step = 48'({16'h0, fout_q} << ls_q);
    assign min_div = (step == 48'h0) ? 48'h0
        : ({12'h0, FVCO_MIN_HZ} + step - 48'h1) / step;
    // Nearest legal value at or above the minimum
    assign hs_try = (min_div < {37'h0, HS_MIN}) ? {37'h0, HS_MIN}
        : min_div;
    assign hs_fix = (hs_try > {37'h0, HS_ODD_MAX} && hs_try[0])
        ? hs_try + 48'h1 : hs_try;
    assign fvco_full = {11'h0, step} * {48'h0, hs_q};
    // Centre feedback with Vc at half supply
    // Division drops the fraction below 2^-32
    assign fb_full = {fvco_q, 36'h0} / {44'h0, FOSC_HZ} >> 4;
    // Integer part by truncation, never rounding
    assign fb_int = fb_q[42:32];
    // Prescaler lookup
    always_comb begin
        if (fb_int < PRESC_T1) begin
            presc_sel = PRESC_V0;
        end else if (fb_int < PRESC_T2) begin
            presc_sel = PRESC_V1;
        end else if (fb_int < PRESC_T3) begin
            presc_sel = PRESC_V2;
        end else begin
            presc_sel = PRESC_V3;
        end
    end
    // 128*80e6/(fvco/p/8) rounded to nearest
    assign gain_num = 43'({16'h0, ADC_NOM_HZ} * {35'h0, GAIN_SCALE}
        * {39'h0, ADC_PRE_DIV} * {38'h0, presc_q});
    assign gain_full = (fvco_q == 36'h0) ? 43'h0
        : (gain_num + {8'h0, fvco_q[35:1]}) / {7'h0, fvco_q};

    // Address and data of each write, in register order
    always_comb begin
        case (widx_q)
            4'h0: wr_word = {32'h0, ADDR_HS_LO, hs_q[7:0]};
            // Packed layout, unused bits zero
            4'h1: wr_word = {32'h0, ADDR_PACKED, 1'b0, ls_q, 1'b0,
                hs_q[10:8]};
            4'h2: wr_word = {32'h0, ADDR_FB0, fb_q[7:0]};
            4'h3: wr_word = {32'h0, 8'(ADDR_FB0 + 8'h1), fb_q[15:8]};
            4'h4: wr_word = {32'h0, 8'(ADDR_FB0 + 8'h2), fb_q[23:16]};
            4'h5: wr_word = {32'h0, 8'(ADDR_FB0 + 8'h3), fb_q[31:24]};
            4'h6: wr_word = {32'h0, 8'(ADDR_FB0 + 8'h4), fb_q[39:32]};
            4'h7: wr_word = {32'h0, ADDR_FB5, 5'h00, fb_q[42:40]};
            default: wr_word = {32'h0, ADDR_GAIN, gain_q};
        endcase
    end

    // Planning sequence
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            fout_q <= 32'h0;
            grade_q <= 2'h0;
            ls_q <= 3'h0;
            hs_q <= 11'h0;
            fvco_q <= 36'h0;
            fb_q <= 43'h0;
            presc_q <= 5'h0;
            gain_q <= 8'h0;
            widx_q <= 4'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            err_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        fout_q <= 32'(fout_req_hz);
                        grade_q <= speed_grade;
                        ls_q <= 3'h0;
                        busy_q <= 1'b1;
                        state_q <= ST_RANGE;
                    end
                end
                ST_RANGE: begin
                    // Grade output ceiling
                    if (fout_q == 32'h0 || fout_q > fout_max(grade_q)) begin
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        state_q <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    // Smallest ratio first, one power per cycle
                    if (hs_fix <= {37'h0, HS_MAX}) begin
                        hs_q <= hs_fix[10:0];
                        state_q <= ST_VCO;
                    end else if (ls_q == LS_CODE_MAX) begin
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        ls_q <= ls_q + 3'h1;
                    end
                end
                ST_VCO: begin
                    // Resulting VCO must sit in the grade range
                    if (fvco_full < {23'h0, FVCO_MIN_HZ}
                        || fvco_full > {23'h0, fvco_max(grade_q)}) begin
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end else begin
                        fvco_q <= fvco_full[35:0];
                        state_q <= ST_FB;
                    end
                end
                ST_FB: begin
                    fb_q <= fb_full[42:0];
                    state_q <= ST_GAIN;
                end
                ST_GAIN: begin
                    // Prescaler first when it changes, then gain; one step if it already matches
                    if (presc_q != presc_sel) begin
                        presc_q <= presc_sel;
                    end else begin
                        gain_q <= gain_full[7:0];
                        widx_q <= 4'h0;
                        state_q <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (widx_q == WRITE_COUNT - 4'h1) begin
                        done_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                    widx_q <= widx_q + 4'h1;
                end
                default: begin
                    busy_q <= 1'b0;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Register path driver: one write per cycle while writing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            wdata_q <= 8'h00;
        end else if (state_q == ST_WRITE) begin
            wr_q <= 1'b1;
            addr_q <= wr_word[15:8];
            wdata_q <= wr_word[7:0];
        end else begin
            wr_q <= 1'b0;
        end
    end

    assign link.wr = wr_q;
    assign link.rd = 1'b0; // The planner never reads back
    assign link.addr = addr_q;
    assign link.wdata = wdata_q;
    assign busy = busy_q;
    assign done = done_q;
    assign plan_error = err_q;
    assign low_speed_divider = ls_q;
    assign high_speed_divider = hs_q;
    assign feedback_divider = fb_q;
    assign gain_prescaler_value = presc_q;
    assign vc_adc_fullscale_gain = gain_q;
endmodule

// file: verification/vcxo_link_chk.sv
`timescale 1ns/1ps
// Watches the write burst from the planner to the oscillator
module vcxo_link_chk (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset, high
    input wire logic wr, // Write strobe
    input wire logic [7:0] addr, // Address
    input wire logic [7:0] wdata // Write data
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // One write to a given register
    sequence s_wr(logic [7:0] a);
        wr && addr == a;
    endsequence
    // Low high-speed byte, then the packed byte
    sequence s_hs_pair;
        s_wr(8'h17) ##1 s_wr(8'h18);
    endsequence
    // Odd values above 33 would break the duty correction
    function automatic logic hs_ok(input logic [10:0] h);
        return h >= 11'h005 && h <= 11'h7fe && (h <= 11'h021 || !h[0]);
    endfunction
    AST_FIRST_WRITE: assert property ($rose(wr) |-> addr == 8'h17)
        else $error("burst does not open at the low divider byte");
    AST_HS_TO_PACKED: assert property (s_wr(8'h17)
        |=> s_wr(8'h18))
        else $error("packed byte does not follow");
    AST_PACKED_TO_FB: assert property (s_wr(8'h18)
        |=> s_wr(8'h1a))
        else $error("feedback bytes do not follow");
    AST_FB_STEP: assert property (wr
        && addr >= 8'h1a && addr <= 8'h1e
        |=> wr && addr == $past(addr) + 8'h01)
        else $error("feedback bytes out of order");
    AST_FB_TO_GAIN: assert property (s_wr(8'h1f) |=> s_wr(8'h23))
        else $error("gain write missing after feedback");
    AST_GAIN_LAST: assert property (s_wr(8'h23) |=> !wr)
        else $error("write after gain");
    AST_PACKED_GAPS: assert property (s_wr(8'h18)
        |-> !wdata[7] && !wdata[3])
        else $error("unused packed bits set");
    AST_LS_CODE: assert property (s_wr(8'h18)
        |-> wdata[6:4] <= 3'h5)
        else $error("low-speed code above five");
    AST_FB_TOP: assert property (s_wr(8'h1f)
        |-> wdata[7:3] == 5'h00)
        else $error("feedback word wider than 43 bits");
    AST_HS_LEGAL: assert property (s_hs_pair |->
        hs_ok({wdata[2:0], $past(wdata)}))
        else $error("illegal high-speed value written");
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
// Plans frequencies and checks the oscillator that receives them
module tb_top;
    import vcxo_pkg::*;
    typedef struct packed {
        logic err; logic [2:0] ls; logic [10:0] hs; logic [42:0] fb;
        logic [4:0] pr; logic [7:0] gn; logic [35:0] fv;
    } plan_t;
    logic ref_clk = 1'b0; // 50 MHz
    logic rst = 1'b1; // Held for four cycles
    logic start = 1'b0; // Plan request
    logic [31:0] fout_req_hz = 32'h0; // Wanted output
    logic [1:0] speed_grade = 2'h0; // Grade
    logic signed [15:0] control_voltage_mv = 16'sh01f4; // Kept positive
    logic [15:0] tuning_gain_ppm_per_volt = 16'h0000; // Pull gain
    logic busy, done, plan_error; // Planner status
    logic [2:0] low_speed_divider; // Planned code
    logic [10:0] high_speed_divider; // Planned ratio
    logic [42:0] feedback_divider; // Planned word
    logic [4:0] gain_prescaler_value; // Planned prescaler
    logic [7:0] vc_adc_fullscale_gain; // Planned gain
    logic [5:0] low_speed_ratio; // Oscillator side
    logic [10:0] high_speed_ratio;
    logic duty_fix_en, hs_setting_bad;
    logic [35:0] fvco_hz, fout_hz;
    int failures = 0;
    int check_count = 0;
    int wr_count = 0;
    logic [35:0] vmax[4] = '{FVCO_MAX_A, FVCO_MAX_B, FVCO_MAX_CD, FVCO_MAX_CD};
    logic [31:0] omax[4] = '{FOUT_MAX_A, FOUT_MAX_B, FOUT_MAX_C, FOUT_MAX_D};
    logic [33:0] corner[7] = '{{2'h3, 32'h0957d0b0}, {2'h2, 32'h17d78400},
        {2'h3, 32'h17d78400}, {2'h0, 32'h0}, {2'h1, 32'h00030d40},
        {2'h0, 32'h9af8da00}, {2'h0, 32'hb2d05e00}};

    // Clock and a count of link writes
    always #10 ref_clk = ~ref_clk;
    vcxo_link_if link_bus (.ref_clk(ref_clk));
    always @(posedge ref_clk) if (link_bus.wr) wr_count <= wr_count + 1;

    vcxo_planner #(.FOUT_W(32)) u_vcxo_planner (.ref_clk(ref_clk), .rst(rst),
        .start(start), .fout_req_hz(fout_req_hz), .speed_grade(speed_grade),
        .link(link_bus), .busy(busy), .done(done), .plan_error(plan_error),
        .low_speed_divider(low_speed_divider),
        .high_speed_divider(high_speed_divider),
        .feedback_divider(feedback_divider),
        .gain_prescaler_value(gain_prescaler_value),
        .vc_adc_fullscale_gain(vc_adc_fullscale_gain));
    vcxo_device u_vcxo_device (.ref_clk(ref_clk), .rst(rst), .link(link_bus),
        .control_voltage_mv(control_voltage_mv),
        .tuning_gain_ppm_per_volt(tuning_gain_ppm_per_volt),
        .low_speed_ratio(low_speed_ratio), .high_speed_ratio(high_speed_ratio),
        .duty_fix_en(duty_fix_en), .hs_setting_bad(hs_setting_bad),
        .fvco_hz(fvco_hz), .fout_hz(fout_hz));
    vcxo_link_chk u_vcxo_link_chk (.ref_clk(ref_clk), .rst(rst),
        .wr(link_bus.wr), .addr(link_bus.addr), .wdata(link_bus.wdata));

    // Independent plan: lowest VCO, smallest low-speed ratio
    function automatic plan_t ref_plan(input logic [63:0] f,
        input logic [1:0] g);
        plan_t p;
        logic [63:0] hs;
        logic [79:0] v;
        int c;
        p = '0;
        p.err = 1'b1;
        if (f == 0 || f > omax[g]) return p;
        for (c = 0; c < 6; c++) begin
            hs = (FVCO_MIN_HZ + (f << c) - 1) / (f << c);
            if (hs < 5) hs = 5;
            if (hs > 33 && hs[0]) hs++;
            if (hs <= 2046) break;
        end
        v = (f * hs) << c;
        if (hs > 2046 || v > vmax[g]) return p;
        p = {1'b0, c[2:0], hs[10:0], 43'((v << 32) / FOSC_HZ), 13'h0, v[35:0]};
        p.pr = p.fb[42:32] < 72 ? 5'h10 : p.fb[42:32] < 79 ? 5'h12 :
            p.fb[42:32] < 86 ? 5'h14 : 5'h16;
        p.gn = 8'((64'h1312d00000 * p.pr + v / 2) / v);
        return p;
    endfunction

    // Pulled VCO from a feedback word; pull is positive so floor is exact
    function automatic logic [35:0] pulled(input logic [42:0] fb);
        logic [79:0] b;
        b = (FOSC_HZ * fb) >> 32;
        return 36'(b + b * 16'(control_voltage_mv) * tuning_gain_ppm_per_volt
            / 80'd1000000000);
    endfunction

    task automatic chk(input string name, input logic [63:0] e,
        input logic [63:0] s);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic check_dev(input plan_t p);
        logic [35:0] fv;
        fv = pulled(p.fb);
        chk("ls_ratio", 6'h01 << p.ls, low_speed_ratio);
        chk("hs_ratio", p.hs, high_speed_ratio);
        chk("duty_fix", p.hs[0] && p.hs <= 33, duty_fix_en);
        chk("hs_bad", 0, hs_setting_bad);
        chk("fvco", fv, fvco_hz);
        chk("fout", (fv >> p.ls) / p.hs, fout_hz);
    endtask

    // One plan; a second start while busy must be ignored
    task automatic plan(input logic [31:0] f, input logic [1:0] g);
        plan_t p;
        int n;
        logic err;
        p = ref_plan(f, g);
        wr_count = 0;
        @(posedge ref_clk);
        start <= 1'b1;
        fout_req_hz <= f;
        speed_grade <= g;
        @(posedge ref_clk);
        fout_req_hz <= f + 32'h1;
        @(posedge ref_clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && plan_error !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        err = plan_error;
        repeat (6) @(posedge ref_clk);
        chk("error", p.err, err);
        chk("writes", p.err ? 0 : 9, wr_count);
        if (!p.err) begin
            chk("ls", p.ls, low_speed_divider);
            chk("hs", p.hs, high_speed_divider);
            chk("fb", p.fb, feedback_divider);
            chk("presc", p.pr, gain_prescaler_value);
            chk("gain", p.gn, vc_adc_fullscale_gain);
            check_dev(p);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence: reset values, corners, then random plans
    initial begin
        plan_t r;
        logic [1:0] g;
        void'($urandom(87011));
        tuning_gain_ppm_per_volt <= 16'($urandom % 200);
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        r = '0;
        r.hs = HS_RESET;
        r.fb = FB_RESET;
        check_dev(r);
        for (int i = 0; i < 7; i++) begin
            plan(corner[i][31:0], corner[i][33:32]);
            if (i == 0) chk("fb_ex", FB_RESET, feedback_divider);
        end
        repeat (16) begin
            g = 2'($urandom % 4);
            plan(32'h00030d40 + $urandom % omax[g], g);
        end
        report_and_stop();
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end
endmodule
